// ==== hw/ssf_defs.svh ====
// socket state / force event register constants
// assumes a 32-bit word bus, byte addresses
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

`define SSF_ADDR_W 8
`define SSF_OFF_PRESENT 8'h08
`define SSF_OFF_FORCE 8'h0C

// present-state and force-event bit positions
`define SSF_B_CAP_Y 31
`define SSF_B_CAP_X 30
`define SSF_B_CAP_LOW 29
`define SSF_B_CAP_HIGH 28
`define SSF_B_VIDEO 27
`define SSF_B_REPROBE 14
`define SSF_B_VOLT_HI 13
`define SSF_B_VOLT_LO 10
`define SSF_B_BADREQ 9
`define SSF_B_LOSS 8
`define SSF_B_UNREC 7
`define SSF_B_READY 6
`define SSF_B_WIDE 5
`define SSF_B_NARROW 4
`define SSF_B_POWER 3
`define SSF_B_DET_B 2
`define SSF_B_DET_A 1
`define SSF_B_STS 0

// reset values
`define SSF_RST_VIDEO 1'b0
`define SSF_RST_VOLT 4'h0
`define SSF_RST_FLAG 1'b0
`define SSF_RST_DET 2'h3
`define SSF_RST_AUTO_PWR 1'b1

// bus responses
`define SSF_RESP_OKAY 2'h0
`define SSF_RESP_SLVERR 2'h2

`endif

// ==== hw/ssf_pkg.sv ====
// types shared by the socket state / force event block
// assumes nothing beyond the constants header
package ssf_pkg;

  // results of one card interrogation, valid with the done pulse
  typedef struct packed {
    logic unrecognized;
    logic wide_bus;
    logic narrow;
    logic [3:0] volt;
  } ssf_probe_type;

  // load of the low event bits of the socket event register
  typedef struct packed {
    logic wr;
    logic power_change_event;
    logic detect_b_event;
    logic detect_a_event;
    logic status_change_event;
  } ssf_evt_force_type;

  // socket pin levels, synchronous to the clock
  typedef struct packed {
    logic detect_pin_a;
    logic detect_pin_b;
    logic card_status_change_pin;
    logic ready_irq_pin;
  } ssf_pins_type;

endpackage

// ==== hw/ssf_regs.sv ====
// socket present-state and force-event registers behind an AXI4-Lite slave
// assumes pins are synchronous to i_clk; the event register, power
// control and the interrogation sequencer live outside this block
// Operation
// - removal with unfinished cycle or buffered writes sets the loss flag
// - unrecognized card sets flag; held until a valid card arrives
// - bit 6 mirrors the live ready/interrupt pin level
// - wide and narrow card flags set by interrogation, held until next recognized card
// - bit 3 shows socket powered up (1) or down (0)
// - bits 2,1 mirror detect pins, frozen during interrogation
// - bit 0 mirrors the live status-change pin level
// - reserved force-event bits always read zero
// - force bit 27 loads the video support bit
// - force bit 14 re-interrogates, refreshes state, re-enables auto power
// - force bits 13..10 load voltage bits; a one disables auto power
// - force bit 9 loads the invalid supply request bit
// - force bits 8,7,5,4 load loss, unrecognized, wide and narrow flags
// - force bit 3 loads the power event, power state untouched
// - force bits 2,1 load detect events, detect levels untouched
// - force bit 0 loads the status event, live level untouched
// - force register only writes through; it stores nothing itself
// - voltage bits refresh at each interrogation done, card type bits only for a recognized card, re-interrogation included
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.svh"

module ssf_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AXI4-Lite slave
  input wire logic [`SSF_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [`SSF_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // socket side
  input wire ssf_pkg::ssf_pins_type i_pins,
  input wire logic i_socket_powered,
  input wire logic i_high_volt_disable,
  input wire logic i_card_removed,
  input wire logic i_cycle_pending,
  input wire logic i_write_buffered,
  input wire logic i_invalid_supply_req,
  input wire logic i_probe_busy,
  input wire logic i_probe_done,
  input wire ssf_pkg::ssf_probe_type i_probe,
  output logic o_reinterrogate,
  output logic o_auto_power_en,
  output ssf_pkg::ssf_evt_force_type o_evt_force
);

  // write and read channel holding state
  logic aw_full_q;
  logic w_full_q;
  logic [`SSF_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic wr_force;
  logic [31:0] rd_word;
  // handshakes and address decode shared by the channel logic
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_hit_force;
  logic ar_hit_present;
  logic ar_hit_force;

  // socket state
  logic video_q;
  logic [3:0] volt_q;
  logic badreq_q;
  logic loss_q;
  logic unrec_q;
  logic wide_q;
  logic narrow_q;
  logic [1:0] det_q;
  logic auto_pwr_q;
  logic reprobe_q;
  ssf_pkg::ssf_evt_force_type evt_q;

  // byte lane qualified write enables into force-event fields
  logic ld_video;
  logic ld_hi;
  logic ld_lo;
  logic reprobe_req;
  logic volt_force_on;

  // awprot and arprot carry no meaning for this block
  assign o_s_axi_awready = !aw_full_q && !bvalid_q;
  assign o_s_axi_wready = !w_full_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign o_s_axi_arready = arready;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_s_axi_rdata = rdata_q;

  // address and data may arrive in either order; commit once both held
  assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take = i_s_axi_wvalid && o_s_axi_wready;
  assign ar_take = i_s_axi_arvalid && arready;
  assign aw_hit_force = (awaddr_q == `SSF_OFF_FORCE);
  assign ar_hit_present = (i_s_axi_araddr == `SSF_OFF_PRESENT);
  assign ar_hit_force = (i_s_axi_araddr == `SSF_OFF_FORCE);
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_force = wr_fire && aw_hit_force;
  assign ld_video = wr_force && wstrb_q[3];
  assign ld_hi = wr_force && wstrb_q[1];
  assign ld_lo = wr_force && wstrb_q[0];
  assign reprobe_req = ld_hi && wdata_q[`SSF_B_REPROBE];
  assign volt_force_on =
    ld_hi && (|wdata_q[`SSF_B_VOLT_HI:`SSF_B_VOLT_LO]);

  // readiness drops while held, so a later beat never overwrites one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_full_q <= 1'b0;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end else if (aw_take) begin
      aw_full_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      awaddr_q <= '0;
    end else if (aw_take) begin
      awaddr_q <= i_s_axi_awaddr;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_full_q <= 1'b0;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end else if (w_take) begin
      w_full_q <= 1'b1;
    end
  end

  // data only loads with its own handshake
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (w_take) begin
      wdata_q <= i_s_axi_wdata;
      wstrb_q <= i_s_axi_wstrb;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_q <= 1'b0;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
    end else if (i_s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // the present-state register is read-only: writes to it are refused
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bresp_q <= `SSF_RESP_OKAY;
    end else if (wr_fire) begin
      bresp_q <= aw_hit_force ? `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
    end
  end

  // read word; live pins sampled at the address handshake
  always_comb begin
    rd_word = '0;
    rd_word[`SSF_B_CAP_Y] = 1'b0;
    rd_word[`SSF_B_CAP_X] = 1'b0;
    rd_word[`SSF_B_CAP_LOW] = 1'b1;
    rd_word[`SSF_B_CAP_HIGH] = !i_high_volt_disable;
    rd_word[`SSF_B_VIDEO] = video_q;
    rd_word[`SSF_B_VOLT_HI:`SSF_B_VOLT_LO] = volt_q;
    rd_word[`SSF_B_BADREQ] = badreq_q;
    rd_word[`SSF_B_LOSS] = loss_q;
    rd_word[`SSF_B_UNREC] = unrec_q;
    rd_word[`SSF_B_READY] = i_pins.ready_irq_pin;
    rd_word[`SSF_B_WIDE] = wide_q;
    rd_word[`SSF_B_NARROW] = narrow_q;
    rd_word[`SSF_B_POWER] = i_socket_powered;
    rd_word[`SSF_B_DET_B] = det_q[1];
    rd_word[`SSF_B_DET_A] = det_q[0];
    rd_word[`SSF_B_STS] = i_pins.card_status_change_pin;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
    end else if (i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // word and response held steady until the master takes them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rresp_q <= `SSF_RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_take) begin
      if (ar_hit_present) begin
        rresp_q <= `SSF_RESP_OKAY;
        rdata_q <= rd_word;
      end else if (ar_hit_force) begin
        // nothing stored behind the force port, so it reads zero
        rresp_q <= `SSF_RESP_OKAY;
        rdata_q <= '0;
      end else begin
        rresp_q <= `SSF_RESP_SLVERR;
        rdata_q <= '0;
      end
    end
  end

  // capability-type bits written through the force port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      video_q <= `SSF_RST_VIDEO;
    end else if (ld_video) begin
      video_q <= wdata_q[`SSF_B_VIDEO];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      volt_q <= `SSF_RST_VOLT;
    end else if (ld_hi) begin
      volt_q <= wdata_q[`SSF_B_VOLT_HI:`SSF_B_VOLT_LO];
    end else if (i_probe_done) begin
      volt_q <= i_probe.volt;
    end
  end

  // power control flags the request; a forced write overrides it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      badreq_q <= `SSF_RST_FLAG;
    end else if (ld_hi) begin
      badreq_q <= wdata_q[`SSF_B_BADREQ];
    end else if (i_invalid_supply_req) begin
      badreq_q <= 1'b1;
    end
  end

  // a removal that may lose data wins over the forced value and the
  // clear at insertion, so the event is never dropped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      loss_q <= `SSF_RST_FLAG;
    end else if (i_card_removed && (i_cycle_pending || i_write_buffered)) begin
      loss_q <= 1'b1;
    end else if (ld_hi) begin
      loss_q <= wdata_q[`SSF_B_LOSS];
    end else if (i_probe_done) begin
      loss_q <= 1'b0;
    end
  end

  // once set, only a valid card (or software) clears it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unrec_q <= `SSF_RST_FLAG;
    end else if (ld_lo) begin
      unrec_q <= wdata_q[`SSF_B_UNREC];
    end else if (i_probe_done) begin
      unrec_q <= i_probe.unrecognized;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wide_q <= `SSF_RST_FLAG;
    end else if (ld_lo) begin
      wide_q <= wdata_q[`SSF_B_WIDE];
    end else if (i_probe_done && !i_probe.unrecognized) begin
      wide_q <= i_probe.wide_bus;
    end
  end

  // an unrecognized card leaves the last valid card type in place
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      narrow_q <= `SSF_RST_FLAG;
    end else if (ld_lo) begin
      narrow_q <= wdata_q[`SSF_B_NARROW];
    end else if (i_probe_done && !i_probe.unrecognized) begin
      narrow_q <= i_probe.narrow;
    end
  end

  // detect levels freeze while the sequencer drives the detect lines;
  // force bits 2,1 never reach here
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_q <= `SSF_RST_DET;
    end else if (!i_probe_busy) begin
      det_q <= {i_pins.detect_pin_b, i_pins.detect_pin_a};
    end
  end

  // forcing a voltage means software owns the power decision;
  // a disable in the same write beats the re-enable
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      auto_pwr_q <= `SSF_RST_AUTO_PWR;
    end else if (volt_force_on) begin
      auto_pwr_q <= 1'b0;
    end else if (reprobe_req) begin
      auto_pwr_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reprobe_q <= 1'b0;
    end else begin
      reprobe_q <= reprobe_req;
    end
  end

  // event loads pass straight to the event register; the power state,
  // detect and status levels here stay untouched
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_q <= '0;
    end else begin
      evt_q.wr <= ld_lo;
      evt_q.power_change_event <= wdata_q[`SSF_B_POWER];
      evt_q.detect_b_event <= wdata_q[`SSF_B_DET_B];
      evt_q.detect_a_event <= wdata_q[`SSF_B_DET_A];
      evt_q.status_change_event <= wdata_q[`SSF_B_STS];
    end
  end

  assign o_reinterrogate = reprobe_q;
  assign o_auto_power_en = auto_pwr_q;
  assign o_evt_force = evt_q;

endmodule

`default_nettype wire

// ==== test/ssf_card_model.sv ====
// card interrogation stand-in: busy for a set delay, then a result
// assumes one request at a time from the register block
`timescale 1ns/1ps
`default_nettype none
module ssf_card_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reinterrogate,
  input wire logic [3:0] i_delay,
  input wire ssf_pkg::ssf_probe_type i_result,
  output logic o_busy,
  output logic o_done,
  output ssf_pkg::ssf_probe_type o_probe
);
  logic [3:0] cnt_q;
  // result lines toggle outside done so stale data cannot pass
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      cnt_q <= 4'h0;
      o_probe <= '0;
    end else begin
      o_done <= o_busy && cnt_q == 4'h0;
      o_probe <= (o_busy && cnt_q == 4'h0) ? i_result : ~o_probe;
      if (i_reinterrogate) begin
        o_busy <= 1'b1;
        cnt_q <= i_delay;
      end else if (o_busy) begin
        o_busy <= cnt_q != 4'h0;
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/ssf_regs_assertions.sv ====
// checker for the socket state / force event register block
// assumes it is bound to ssf_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.svh"
module ssf_regs_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic [`SSF_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire ssf_pkg::ssf_pins_type i_pins,
  input wire logic i_socket_powered,
  input wire logic o_reinterrogate,
  input wire ssf_pkg::ssf_evt_force_type o_evt_force
);
  logic [7:0] ra_q;
  logic ar_go;
  logic wr_go;
  assign ar_go = i_s_axi_arvalid && o_s_axi_arready;
  assign wr_go = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
    && o_s_axi_wready;
  // read address kept so the answer can be judged by its target
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      ra_q <= 8'h00;
    else if (ar_go)
      ra_q <= i_s_axi_araddr;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_write_answer: assert property (wr_go |-> ##2 o_s_axi_bvalid)
    else $error("write answer not two cycles after address and data");
  a_read_answer: assert property (ar_go |=> o_s_axi_rvalid)
    else $error("read answer not one cycle after address");
  a_busy_refuse: assert property (o_s_axi_bvalid |-> !o_s_axi_awready
    && !o_s_axi_wready)
    else $error("write accepted while response pending");
  a_pin_mirror: assert property (ar_go && i_s_axi_araddr ==
    `SSF_OFF_PRESENT |=> o_s_axi_rdata[6] == $past(i_pins.ready_irq_pin)
    && o_s_axi_rdata[0] == $past(i_pins.card_status_change_pin)
    && o_s_axi_rdata[3] == $past(i_socket_powered))
    else $error("live pin level not mirrored");
  a_force_zero: assert property (o_s_axi_rvalid && ra_q == `SSF_OFF_FORCE
    |-> o_s_axi_rdata == 32'h0)
    else $error("force register read not zero");
  a_state_spare: assert property (o_s_axi_rvalid && ra_q ==
    `SSF_OFF_PRESENT |-> o_s_axi_rdata[26:14] == 13'h0)
    else $error("spare state bits not zero");
  a_reprobe_pulse: assert property (o_reinterrogate |->
    $rose(o_s_axi_bvalid) ##1 !o_reinterrogate)
    else $error("reinterrogate pulse misplaced");
  a_event_pulse: assert property (o_evt_force.wr |->
    $rose(o_s_axi_bvalid) ##1 !o_evt_force.wr)
    else $error("event load pulse misplaced");
  c_write: cover property (wr_go);
  c_reprobe: cover property (o_reinterrogate);
  c_event: cover property (o_evt_force.wr);
endmodule
bind ssf_regs ssf_regs_assertions ssf_regs_assertions_inst (.i_clk,
  .i_rst_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_araddr, .i_s_axi_arvalid,
  .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_pins,
  .i_socket_powered, .o_reinterrogate, .o_evt_force);
`default_nettype wire

// ==== test/ssf_regs_bench.sv ====
// random and corner bench for the socket state / force registers
// assumes the card model stands in for the interrogation sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.svh"
module ssf_regs_bench;
  logic i_clk, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready, o_s_axi_wready;
  logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, got, r;
  logic [3:0] i_s_axi_wstrb, dly, volt;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp, det;
  ssf_pkg::ssf_pins_type i_pins;
  ssf_pkg::ssf_probe_type i_probe, res;
  ssf_pkg::ssf_evt_force_type o_evt_force, evt_q;
  logic i_socket_powered, i_high_volt_disable, i_card_removed;
  logic i_cycle_pending, i_write_buffered, i_invalid_supply_req;
  logic i_probe_busy, i_probe_done, o_reinterrogate, o_auto_power_en;
  logic vid, bad, loss, unrec, wide, narrow, ape;
  int num_errors, n_compared, seed;
  ssf_regs ssf_regs_inst (.i_clk, .i_rst_n, .i_s_axi_awaddr,
    .i_s_axi_awprot(3'h0), .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arprot(3'h0), .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_pins, .i_socket_powered, .i_high_volt_disable, .i_card_removed,
    .i_cycle_pending, .i_write_buffered, .i_invalid_supply_req,
    .i_probe_busy, .i_probe_done, .i_probe, .o_reinterrogate,
    .o_auto_power_en, .o_evt_force);
  ssf_card_model ssf_card_model_inst (.i_clk, .i_rst_n,
    .i_reinterrogate(o_reinterrogate), .i_delay(dly), .i_result(res),
    .o_busy(i_probe_busy), .o_done(i_probe_done), .o_probe(i_probe));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // sampled mid-cycle, the pulse is gone by the time the write returns
  always @(negedge i_clk) if (o_evt_force.wr) evt_q = o_evt_force;
  function automatic logic [31:0] present();
    return {3'h1, !i_high_volt_disable, vid, 13'h0, volt, bad, loss, unrec,
      i_pins.ready_irq_pin, wide, narrow, i_socket_powered, det,
      i_pins.card_status_change_pin};
  endfunction
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, fin;
    fin = 1'b0;
    @(posedge i_clk);
    if (w) begin
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_wstrb <= s;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
    end else begin
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
    end
    for (int n = 0; n < 40 && !fin; n++) begin
      @(negedge i_clk);
      ta = w ? i_s_axi_awvalid && o_s_axi_awready
        : i_s_axi_arvalid && o_s_axi_arready;
      tw = i_s_axi_wvalid && o_s_axi_wready;
      fin = w ? o_s_axi_bvalid : o_s_axi_rvalid;
      resp = w ? o_s_axi_bresp : o_s_axi_rresp;
      got = o_s_axi_rdata;
      @(posedge i_clk);
      if (ta) begin
        i_s_axi_awvalid <= 1'b0;
        i_s_axi_arvalid <= 1'b0;
      end
      if (tw) i_s_axi_wvalid <= 1'b0;
      if (fin) begin
        i_s_axi_bready <= 1'b0;
        i_s_axi_rready <= 1'b0;
      end
    end
    if (!fin) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    bus(1'b0, a, 32'h0, 4'h0);
    chk({30'h0, resp}, {30'h0, er});
    chk(got, e);
  endtask
  task automatic force_wr(input logic [31:0] d, input logic [3:0] s);
    evt_q = '0;
    bus(1'b1, `SSF_OFF_FORCE, d, s);
    chk({30'h0, resp}, {30'h0, `SSF_RESP_OKAY});
    if (s[3]) vid = d[27];
    if (s[1]) begin
      {volt, bad, loss} = d[13:8];
      if (d[14]) ape = 1'b1;
      if (|d[13:10]) ape = 1'b0;
    end
    if (s[0]) {unrec, wide, narrow} = {d[7], d[5:4]};
    chk({27'h0, evt_q}, {27'h0, s[0], d[3:0] & {4{s[0]}}});
    chk({31'h0, o_auto_power_en}, {31'h0, ape});
  endtask
  task automatic await(input logic sel);
    for (int n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (sel ? i_probe_done : i_probe_busy) return;
    end
    num_errors++;
    conclude();
  endtask
  initial begin
    seed = 32'hC052;
    {num_errors, n_compared} = 64'h0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
    {i_s_axi_arvalid, i_s_axi_rready, i_card_removed} = 3'h0;
    {i_socket_powered, i_high_volt_disable, i_cycle_pending} = 3'h0;
    {i_write_buffered, i_invalid_supply_req, dly, res} = 13'h0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wstrb} = 20'h0;
    {i_s_axi_wdata, evt_q} = 37'h0;
    {vid, bad, loss, unrec, wide, narrow, volt} = 10'h0;
    {i_pins, det, ape} = 7'h7F;
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(`SSF_OFF_PRESENT, present(), `SSF_RESP_OKAY);
    rd(8'h04, 32'h0, `SSF_RESP_SLVERR);
    bus(1'b1, `SSF_OFF_PRESENT, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, resp}, {30'h0, `SSF_RESP_SLVERR});
    rd(`SSF_OFF_PRESENT, present(), `SSF_RESP_OKAY);
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      i_pins <= r[3:0];
      {i_socket_powered, i_high_volt_disable} <= r[7:6];
      {i_cycle_pending, i_write_buffered} <= r[5:4];
      {i_invalid_supply_req, i_card_removed} <= r[9:8];
      @(posedge i_clk);
      {i_invalid_supply_req, i_card_removed} <= 2'h0;
      loss |= r[8] & (r[5] | r[4]);
      bad |= r[9];
      det = {r[2], r[3]};
      rd(`SSF_OFF_PRESENT, present(), `SSF_RESP_OKAY);
      force_wr($random(seed) & 32'hFFFF_BFFF, r[13:10]);
      rd(`SSF_OFF_PRESENT, present(), `SSF_RESP_OKAY);
    end
    rd(`SSF_OFF_FORCE, 32'h0, `SSF_RESP_OKAY);
    force_wr(32'h0000_0400, 4'h2);
    for (int k = 0; k < 2; k++) begin
      r = $random(seed);
      dly <= k ? 4'h9 : 4'h0;
      res <= {k[0], r[5:0]};
      force_wr(32'h0000_4000, 4'h2);
      if (k) begin
        await(1'b0);
        i_pins <= ~i_pins;
        @(posedge i_clk);
        rd(`SSF_OFF_PRESENT, present(), `SSF_RESP_OKAY);
      end
      await(1'b1);
      {volt, loss, unrec} = {res.volt, 1'b0, res.unrecognized};
      if (!res.unrecognized) {wide, narrow} = {res.wide_bus, res.narrow};
      det = {i_pins.detect_pin_b, i_pins.detect_pin_a};
      rd(`SSF_OFF_PRESENT, present(), `SSF_RESP_OKAY);
    end
    conclude();
  end
endmodule
`default_nettype wire
